// [hdl/port23_pkg.sv]
// Constants shared by the second and third parallel port block
package port23_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] P2_DIR_IDX    = 16'hFFC1;
  localparam logic [15:0] P2_LATCH_IDX  = 16'hFFC3;
  localparam logic [15:0] P3_DIR_IDX    = 16'hFFC4;
  localparam logic [15:0] P3_LATCH_IDX  = 16'hFFC6;
  localparam logic [15:0] P2_PULLUP_IDX = 16'hFFD8;
  localparam int          ADDR_W        = 18;
  localparam int          IDX_LSB       = 2;
  // Reset values and fixed read answers
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [7:0]  ALL_ONES      = 8'hFF;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Operating mode codes
  localparam logic [2:0]  MODE_EXP_NOROM_A = 3'h1;
  localparam logic [2:0]  MODE_EXP_NOROM_B = 3'h3;
  localparam logic [2:0]  MODE_EXP_ROM     = 3'h5;
endpackage

// [hdl/mode_dependent_io_ports.sv]
// Second and third parallel ports with mode dependent pin functions
//
// Summary of operation
// - Pull-up on only when enabled, input, ROM modes
// - ROM-off expanded modes: pull-ups always off
// - Pull-up control register: 8-bit read/write
// - Pull-up register clears on reset, hardware standby
// - Pull-ups off at reset; held in software standby
// - ROM-off expanded modes: second port drives address
// - ROM expanded: direction picks address or input
// - Single-chip: second port direction picks output/input
// - Expanded modes: third port is data bus
// - Single-chip: third port drives latch when output
// - Third port direction register: 8-bit write-only
// - Third port direction reads as all ones
// - Third port direction clears on reset, hardware standby
// - Output pins hold level in software standby
// - Third port read: latch if output, else pin
// - Third port latch read/write, clears on reset
// - Second port direction write-only, clears on reset
// - Second port read: latch if output, else pin
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module mode_dependent_io_ports
  import port23_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic [2:0]        mode_i,
  input  wire logic              hw_standby_i,
  input  wire logic              sw_standby_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [7:0]        addr_hi_i,
  input  wire logic              ext_data_oe_i,
  input  wire logic [7:0]        ext_data_i,
  output logic [7:0]             ext_data_o,
  input  wire logic [7:0]        p2_in_i,
  output logic [7:0]             p2_out_o,
  output logic [7:0]             p2_oe_o,
  output logic [7:0]             p2_pullup_o,
  input  wire logic [7:0]        p3_in_i,
  output logic [7:0]             p3_out_o,
  output logic [7:0]             p3_oe_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Expanded modes with on-chip ROM switched off
  function automatic logic rom_off(input logic [2:0] m);
    rom_off = (m == MODE_EXP_NOROM_A) || (m == MODE_EXP_NOROM_B);
  endfunction

  // All expanded modes; unused codes behave as single-chip
  function automatic logic expanded(input logic [2:0] m);
    expanded = rom_off(m) || (m == MODE_EXP_ROM);
  endfunction

  // Port read: latch for output pins, pin level for inputs
  function automatic logic [7:0] port_read(input logic [7:0] dir,
                                           input logic [7:0] lat,
                                           input logic [7:0] pin);
    port_read = (dir & lat) | (~dir & pin);
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] mode_s1_reg, mode_s2_reg;
  logic       hws_s1_reg, hws_s2_reg;
  logic [7:0] p2_s1_reg, p2_s2_reg;
  logic [7:0] p3_s1_reg, p3_s2_reg;

  // Pins and straps come from outside the clock domain
  always_ff @(posedge mclk_i)
  begin
    mode_s1_reg <= mode_i;
    mode_s2_reg <= mode_s1_reg;
    hws_s1_reg  <= hw_standby_i;
    hws_s2_reg  <= hws_s1_reg;
    p2_s1_reg   <= p2_in_i;
    p2_s2_reg   <= p2_s1_reg;
    p3_s1_reg   <= p3_in_i;
    p3_s2_reg   <= p3_s1_reg;
  end

  logic clear_all;
  logic is_rom_off;
  logic is_exp;
  // Hardware standby clears state just as reset does
  assign clear_all  = reset_i || hws_s2_reg;
  assign is_rom_off = rom_off(mode_s2_reg);
  assign is_exp     = expanded(mode_s2_reg);

  // ****************************************************************
  // Avalon-MM slave and port registers
  // ****************************************************************
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  p2_dir_reg, p2_dir_next;
  logic [7:0]  p2_lat_reg, p2_lat_next;
  logic [7:0]  p2_pcr_reg, p2_pcr_next;
  logic [7:0]  p3_dir_reg, p3_dir_next;
  logic [7:0]  p3_lat_reg, p3_lat_next;
  logic [15:0] idx;
  logic        req;
  logic        wr_take;

  assign idx     = avs_address_i[ADDR_W-1:IDX_LSB];
  assign req     = avs_read_i || avs_write_i;
  assign wr_take = avs_write_i && !wait_reg && avs_byteenable_i[0];

  // One wait cycle per access; write lands on the acknowledging edge
  always_comb
  begin
    wait_next   = !(req && wait_reg);
    rdata_next  = rdata_reg;
    p2_dir_next = p2_dir_reg;
    p2_lat_next = p2_lat_reg;
    p2_pcr_next = p2_pcr_reg;
    p3_dir_next = p3_dir_reg;
    p3_lat_next = p3_lat_reg;
    if (avs_read_i && wait_reg)
    begin
      rdata_next = UNMAPPED_READ;
      case (idx)
        P2_DIR_IDX:    rdata_next[7:0] = ALL_ONES;
        P2_LATCH_IDX:  rdata_next[7:0] = port_read(p2_dir_reg, p2_lat_reg,
                                                   p2_s2_reg);
        P2_PULLUP_IDX: rdata_next[7:0] = p2_pcr_reg;
        P3_DIR_IDX:    rdata_next[7:0] = ALL_ONES;
        P3_LATCH_IDX:  rdata_next[7:0] = port_read(p3_dir_reg, p3_lat_reg,
                                                   p3_s2_reg);
        default:       rdata_next      = UNMAPPED_READ;
      endcase
    end
    if (wr_take)
    begin
      case (idx)
        P2_DIR_IDX:    p2_dir_next = avs_writedata_i[7:0];
        P2_LATCH_IDX:  p2_lat_next = avs_writedata_i[7:0];
        P2_PULLUP_IDX: p2_pcr_next = avs_writedata_i[7:0];
        P3_DIR_IDX:    p3_dir_next = avs_writedata_i[7:0];
        P3_LATCH_IDX:  p3_lat_next = avs_writedata_i[7:0];
        default:       p3_lat_next = p3_lat_reg;
      endcase
    end
  end

  // Registers survive software standby simply by not being cleared
  always_ff @(posedge mclk_i)
  begin
    if (clear_all)
    begin
      wait_reg   <= 1'b1;
      rdata_reg  <= UNMAPPED_READ;
      p2_dir_reg <= REG_RESET;
      p2_lat_reg <= REG_RESET;
      p2_pcr_reg <= REG_RESET;
      p3_dir_reg <= REG_RESET;
      p3_lat_reg <= REG_RESET;
    end
    else
    begin
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
      p2_dir_reg <= p2_dir_next;
      p2_lat_reg <= p2_lat_next;
      p2_pcr_reg <= p2_pcr_next;
      p3_dir_reg <= p3_dir_next;
      p3_lat_reg <= p3_lat_next;
    end
  end

  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o    = rdata_reg;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [7:0] p2_out_reg, p2_out_next;
  logic [7:0] p2_oe_reg, p2_oe_next;
  logic [7:0] p2_pu_reg, p2_pu_next;
  logic [7:0] p3_out_reg, p3_out_next;
  logic [7:0] p3_oe_reg, p3_oe_next;
  logic [7:0] ext_rd_reg, ext_rd_next;

  // Pin functions per mode; software standby freezes every pin
  always_comb
  begin
    p2_out_next = p2_out_reg;
    p2_oe_next  = p2_oe_reg;
    p2_pu_next  = p2_pu_reg;
    p3_out_next = p3_out_reg;
    p3_oe_next  = p3_oe_reg;
    ext_rd_next = p3_s2_reg;
    if (!sw_standby_i)
    begin
      p2_pu_next = p2_pcr_reg & ~p2_dir_reg;
      if (is_rom_off)
      begin
        p2_oe_next  = ALL_ONES;
        p2_out_next = addr_hi_i;
      end
      else if (is_exp)
      begin
        p2_oe_next  = p2_dir_reg;
        p2_out_next = addr_hi_i;
      end
      else
      begin
        p2_oe_next  = p2_dir_reg;
        p2_out_next = p2_lat_reg;
      end
      if (is_exp)
      begin
        p3_oe_next  = {8{ext_data_oe_i}};
        p3_out_next = ext_data_i;
      end
      else
      begin
        p3_oe_next  = p3_dir_reg;
        p3_out_next = p3_lat_reg;
      end
    end
    // Bus addressing without ROM never enables pull-ups, even frozen
    if (is_rom_off)
    begin
      p2_pu_next = REG_RESET;
    end
  end

  // Pins release and pull-ups drop during reset and hardware standby
  always_ff @(posedge mclk_i)
  begin
    if (clear_all)
    begin
      p2_out_reg <= REG_RESET;
      p2_oe_reg  <= REG_RESET;
      p2_pu_reg  <= REG_RESET;
      p3_out_reg <= REG_RESET;
      p3_oe_reg  <= REG_RESET;
      ext_rd_reg <= REG_RESET;
    end
    else
    begin
      p2_out_reg <= p2_out_next;
      p2_oe_reg  <= p2_oe_next;
      p2_pu_reg  <= p2_pu_next;
      p3_out_reg <= p3_out_next;
      p3_oe_reg  <= p3_oe_next;
      ext_rd_reg <= ext_rd_next;
    end
  end

  assign p2_out_o    = p2_out_reg;
  assign p2_oe_o     = p2_oe_reg;
  assign p2_pullup_o = p2_pu_reg;
  assign p3_out_o    = p3_out_reg;
  assign p3_oe_o     = p3_oe_reg;
  assign ext_data_o  = ext_rd_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  pullup_rom_off_a: assert property (is_rom_off && $past(is_rom_off)
    |-> p2_pullup_o == REG_RESET) else $error("pull-up on without ROM");
  // Old direction: the pull-up gated by a new direction lands one edge after the direction
  pullup_gate_a: assert property (!sw_standby_i && !clear_all && !is_rom_off
    |=> (p2_pullup_o & $past(p2_dir_reg)) == REG_RESET)
    else $error("pull-up on for output pin");
  pcr_clear_a: assert property (hws_s2_reg |=> p2_pcr_reg == REG_RESET
    && p2_pullup_o == REG_RESET) else $error("standby did not clear");
  dir_read_a: assert property (avs_read_i && wait_reg && idx == P3_DIR_IDX
    && !clear_all |=> avs_readdata_o[7:0] == ALL_ONES)
    else $error("direction read not all ones");
  wait_one_a: assert property (req && wait_reg && !clear_all
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("wait cycle count wrong");
  p2_addr_a: assert property (is_rom_off && !sw_standby_i && !clear_all
    |=> p2_oe_o == ALL_ONES && p2_out_o == $past(addr_hi_i))
    else $error("address not driven");
  p3_bus_a: assert property (is_exp && !sw_standby_i && !clear_all
    |=> p3_oe_o == {8{$past(ext_data_oe_i)}} && p3_out_o == $past(ext_data_i))
    else $error("data bus not followed");
  p3_single_a: assert property (!is_exp && !sw_standby_i && !clear_all
    |=> p3_oe_o == $past(p3_dir_reg) && p3_out_o == $past(p3_lat_reg))
    else $error("third port not from latch");
  stby_hold_a: assert property (sw_standby_i && !clear_all
    |=> $stable(p3_oe_o) && $stable(p3_out_o) && $stable(p2_oe_o))
    else $error("pins moved in standby");

  cov_p3_write_c: cover property (wr_take && idx == P3_LATCH_IDX);
  cov_p2_read_c:  cover property (avs_read_i && !wait_reg && idx == P2_LATCH_IDX);
  cov_pullup_c:   cover property (p2_pullup_o != REG_RESET);
  cov_stby_c:     cover property (sw_standby_i && p3_oe_o != REG_RESET);

endmodule // mode_dependent_io_ports

// [sim/pin_world.sv]
// Pin-side model: external drivers and pull-ups on the port pins
`timescale 1ns/1ps
// ****************************************
// Pin level resolution
// ****************************************
module pin_world (
  input  wire logic [7:0] p2_out_i,
  input  wire logic [7:0] p2_oe_i,
  input  wire logic [7:0] p2_pullup_i,
  input  wire logic [7:0] p3_out_i,
  input  wire logic [7:0] p3_oe_i,
  input  wire logic [7:0] ext2_i,
  input  wire logic [7:0] ext3_i,
  output logic [7:0]      p2_level_o,
  output logic [7:0]      p3_level_o
);
  // Outside parts drive released pins; an enabled pull-up forces the level high over them
  assign p2_level_o = (p2_oe_i & p2_out_i) | (~p2_oe_i & (p2_pullup_i | ext2_i));
  // No pull-ups on the third port, so an external level is always present
  assign p3_level_o = (p3_oe_i & p3_out_i) | (~p3_oe_i & ext3_i);
endmodule // pin_world

// [sim/mode_dependent_io_ports_tb.sv]
// Self-checking bench for the second and third port block
`timescale 1ns/1ps
module mode_dependent_io_ports_tb;
  import port23_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        mclk, rst, hws, sws, rd, wr, xoe, wreq;
  logic [2:0]  mode;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  be;
  logic [7:0]  ahi, xd, xo, p2i, p2o, p2e, p2u, p3i, p3o, p3e, e2, e3;
  logic [7:0]  d2, l2, pc, d3, l3, old;
  logic [7:0]  q[$];
  logic [2:0]  ml [6] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0};
  int          miscompares, samples_checked;

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  mode_dependent_io_ports i_dut (
    .mclk_i(mclk), .reset_i(rst), .mode_i(mode), .hw_standby_i(hws), .sw_standby_i(sws),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .addr_hi_i(ahi), .ext_data_oe_i(xoe), .ext_data_i(xd), .ext_data_o(xo),
    .p2_in_i(p2i), .p2_out_o(p2o), .p2_oe_o(p2e), .p2_pullup_o(p2u),
    .p3_in_i(p3i), .p3_out_o(p3o), .p3_oe_o(p3e));

  pin_world i_pins (.p2_out_i(p2o), .p2_oe_i(p2e), .p2_pullup_i(p2u), .p3_out_i(p3o),
    .p3_oe_i(p3e), .ext2_i(e2), .ext3_i(e3), .p2_level_o(p2i), .p3_level_o(p3i));

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (e !== g)
    begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Holds the request until waitrequest is seen low, then lets one edge pass
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
                     input logic [3:0] b);
    adr  <= {i, 2'b00};
    wdat <= {24'h000000, d};
    be   <= b;
    rd   <= ~w;
    wr   <= w;
    // Only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge mclk);
    end
    while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdx(input logic [15:0] i, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, i, 8'h00, 4'hF);
  endtask

  task automatic wrx(input logic [15:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 4'h1);
  endtask

  // Read results are compared in order against the notes of the driver
  always @(posedge mclk)
    if (rd === 1'b1 && wreq === 1'b0)
    begin
      chk(q.pop_front(), rdat[7:0]);
      // Only the low byte carries a register; the rest must read as zero
      chk(8'h00, rdat[31:24] | rdat[23:16] | rdat[15:8]);
    end

  // ****************************************
  // One mode with random register and pin values
  // ****************************************
  task automatic run_mode(input logic [2:0] m);
    logic       nr, sc;
    logic [7:0] pin3;
    nr = (m == MODE_EXP_NOROM_A) || (m == MODE_EXP_NOROM_B);
    sc = !nr && (m != MODE_EXP_ROM);
    mode <= m;
    d2 = 8'($urandom);
    l2 = 8'($urandom);
    pc = 8'($urandom);
    d3 = 8'($urandom);
    l3 = 8'($urandom);
    e2 <= 8'($urandom);
    e3 <= 8'($urandom);
    ahi <= 8'($urandom);
    xd <= 8'($urandom);
    xoe <= 1'($urandom);
    repeat (3) @(posedge mclk);
    wrx(P2_DIR_IDX, d2);
    wrx(P2_LATCH_IDX, l2);
    wrx(P2_PULLUP_IDX, pc);
    wrx(P3_DIR_IDX, d3);
    wrx(P3_LATCH_IDX, l3);
    bus(1'b1, P3_LATCH_IDX, ~l3, 4'h0);
    repeat (4) @(posedge mclk);
    pin3 = sc ? (d3 & l3) | (~d3 & e3) : (xoe ? xd : e3);
    chk(nr ? 8'hFF : d2, p2e);
    chk((sc ? l2 : ahi) & p2e, p2o & p2e);
    chk(nr ? 8'h00 : pc & ~d2, p2u);
    chk(sc ? d3 : {8{xoe}}, p3e);
    chk((sc ? l3 : xd) & p3e, p3o & p3e);
    chk(pin3, xo);
    rdx(P2_PULLUP_IDX, pc);
    rdx(P3_DIR_IDX, ALL_ONES);
    rdx(P2_DIR_IDX, ALL_ONES);
    if (sc) rdx(P3_LATCH_IDX, pin3);
    if (!nr) rdx(P2_LATCH_IDX, (d2 & l2) | (~d2 & (pc | e2)));
    $display("mode %0d test done", m);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is under a thousand cycles; 20000 leaves a wide margin
  initial
  begin
    #500000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    {rst, hws, sws, rd, wr, xoe} = 6'b100000;
    {mode, adr, wdat, be} = {3'h7, 18'h00000, 32'h00000000, 4'h0};
    {ahi, xd, e2, e3} = 32'h00000000;
    void'($urandom(32'h02E53475));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(8'h00, p2e | p3e | p2u);
    rdx(P2_PULLUP_IDX, REG_RESET);
    rdx(16'h0123, UNMAPPED_READ[7:0]);
    $display("reset test done");
    for (int k = 0; k < 3; k++)
      foreach (ml[j]) run_mode(ml[j]);
    // Frozen pins while asleep, even as the address source moves
    run_mode(MODE_EXP_ROM);
    old = ahi;
    sws <= 1'b1;
    @(posedge mclk);
    ahi <= ~ahi;
    repeat (4) @(posedge mclk);
    chk(d2, p2e);
    chk(old & d2, p2o & d2);
    chk(pc & ~d2, p2u);
    sws <= 1'b0;
    repeat (2) @(posedge mclk);
    rdx(P2_PULLUP_IDX, pc);
    $display("software standby test done");
    // Hardware standby clears everything like a reset
    hws <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(8'h00, p2u | p2e | p3e);
    hws <= 1'b0;
    mode <= 3'h7;
    repeat (4) @(posedge mclk);
    chk(8'h00, p3e | p2e);
    rdx(P2_PULLUP_IDX, REG_RESET);
    wrx(P3_DIR_IDX, 8'hFF);
    wrx(P2_DIR_IDX, 8'hFF);
    rdx(P3_LATCH_IDX, REG_RESET);
    rdx(P2_LATCH_IDX, REG_RESET);
    $display("hardware standby test done");
    stop_test();
  end
endmodule // mode_dependent_io_ports_tb
